// File: verilog/prpc_defines.vh
// constants for the reset and power-state control block
`ifndef PRPC_DEFINES_VH
`define PRPC_DEFINES_VH
// ****************************************************
// register offsets
// ****************************************************
`define PRPC_OFF_BASIC_CONTROL   5'h00
`define PRPC_OFF_ENERGY_DETECT   5'h1d
// ****************************************************
// field positions
// ****************************************************
`define PRPC_BC_RESET_BIT        15
`define PRPC_BC_POWER_DOWN_BIT   11
`define PRPC_SENSE_ENABLE_BIT    15
`define PRPC_SENSE_PERIOD_LSB    0
`define PRPC_SENSE_PERIOD_MSB    7
// ****************************************************
// reset values
// ****************************************************
`define PRPC_BC_RESET_VALUE      16'h3000
`define PRPC_SENSE_RESET_VALUE   16'h0010
// ****************************************************
// timing
// ****************************************************
// cycle counts are the nanosecond figures over the clock period, sized for the 16-bit counters
`define PRPC_CLK_PERIOD_NS       10
`define PRPC_SOFT_RESET_NS       1000
`define PRPC_SOFT_RESET_CYCLES   16'h0064
`define PRPC_WAKE_UP_NS          1000
`define PRPC_WAKE_UP_CYCLES      16'h0064
`define PRPC_PROBE_UNIT_CYCLES   1024
`endif

// File: verilog/prpc_timer.v
// down counter that raises done for one cycle when a loaded count expires
`timescale 1ns/1ps
module prpc_timer #(
	parameter WIDTH = 16
) (
	input  wire             clk,
	input  wire             nrst,
	input  wire             load,
	input  wire [WIDTH-1:0] count,
	input  wire             stop,
	output reg              busy,
	output reg              done
);
	reg [WIDTH-1:0] remain;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			remain <= {WIDTH{1'b0}};
			busy   <= 1'b0;
			done   <= 1'b0;
		end else begin
			done <= 1'b0;
			if (stop) begin
				busy   <= 1'b0;
				remain <= {WIDTH{1'b0}};
			end else if (load) begin
				busy   <= 1'b1;
				remain <= count;
			end else if (busy) begin
				if (remain <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule

// File: verilog/prpc_core.v
// reset and power-state control with management register access
// How it works
// R01: writing one to power-down bit 11 of register 0x00 enters power-down
// R02: energy sense enabled and line quiet keeps the block in low power
// R03: line activity in low power runs the normal power-up sequence
// R04: in low power, the transmitter wakes periodically to send detection probes
// R05: energy sense is enabled and configured in register 0x1d
// R06: power-on reset is generated internally, no external reset needed
// R07: the host holds the reset pin low for at least one microsecond
// R08: hardware reset restores register defaults and re-samples the straps
// R09: writing one to bit 15 of register 0x00 starts software reset
// R10: software reset completes about one microsecond after the write
// R11: software reset restores defaults but keeps the latched straps
// R12: host waits three microseconds after software reset before management access
// R13: reset bit reads one while reset runs and clears itself after
`timescale 1ns/1ps
`include "prpc_defines.vh"
module prpc_core #(
	parameter STRAP_WIDTH = 4
) (
	input  wire                   clk,
	input  wire                   nrst,
	input  wire                   reset_n_pin,
	input  wire [STRAP_WIDTH-1:0] strap_in,
	input  wire                   reg_wr,
	input  wire                   reg_rd,
	input  wire [4:0]             reg_addr,
	input  wire [15:0]            reg_wdata,
	input  wire                   line_activity,
	output reg  [15:0]            reg_rdata,
	output reg                    reg_rvalid,
	output reg  [STRAP_WIDTH-1:0] strap_latched,
	output reg                    soft_reset_active,
	output reg                    core_reset_n,
	output reg                    power_down,
	output reg                    energy_sense_low_power,
	output reg                    tx_wake,
	output reg                    tx_probe
);
// ****************************************************
// power-on and hardware reset
// ****************************************************
	// nrst stands for the internal power-on reset; the pin is sampled as a plain input
	reg        hw_reset_seen;
	reg        strap_capture;

	always @(posedge clk or negedge nrst) begin // [R06]
		if (!nrst) begin
			hw_reset_seen <= 1'b1;
			strap_capture <= 1'b1;
		end else begin
			hw_reset_seen <= ~reset_n_pin;
			strap_capture <= hw_reset_seen & reset_n_pin; // re-latch on release [R08]
		end
	end

	// pin lows shorter than the host must give are not filtered here [R07]
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			strap_latched <= {STRAP_WIDTH{1'b0}};
		end else if (strap_capture) begin
			strap_latched <= strap_in; // [R08]
		end
	end
// ****************************************************
// software reset
// ****************************************************
	wire bc_write = reg_wr & (reg_addr == `PRPC_OFF_BASIC_CONTROL);
	wire sense_write = reg_wr & (reg_addr == `PRPC_OFF_ENERGY_DETECT);
	wire soft_start = bc_write & reg_wdata[`PRPC_BC_RESET_BIT] & ~soft_reset_active; // [R09]
	wire soft_done;

	prpc_timer #(.WIDTH(16)) u_soft_timer (
		.clk   (clk),
		.nrst  (nrst),
		.load  (soft_start),
		.count (`PRPC_SOFT_RESET_CYCLES),
		.stop  (hw_reset_seen),
		.busy  (),
		.done  (soft_done)
	);

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			soft_reset_active <= 1'b0;
		end else if (hw_reset_seen | soft_done) begin
			soft_reset_active <= 1'b0; // self-clearing [R10] [R13]
		end else if (soft_start) begin
			soft_reset_active <= 1'b1; // [R09]
		end
	end

	// register clear that both reset kinds share; straps untouched here [R11]
	wire regs_clear = hw_reset_seen | soft_done;
	// the rest of the device stays held while either reset runs
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			core_reset_n <= 1'b0;
		end else begin
			core_reset_n <= ~(hw_reset_seen | soft_reset_active | soft_start);
		end
	end
	// host must leave the bus quiet 3 us after soft reset; accesses are not policed [R12]
// ****************************************************
// registers
// ****************************************************
	reg [15:0] basic_control_reg;
	reg [15:0] energy_detect_ctrl_reg;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			basic_control_reg      <= `PRPC_BC_RESET_VALUE;
			energy_detect_ctrl_reg <= `PRPC_SENSE_RESET_VALUE;
		end else if (regs_clear) begin
			basic_control_reg      <= `PRPC_BC_RESET_VALUE; // [R08] [R11]
			energy_detect_ctrl_reg <= `PRPC_SENSE_RESET_VALUE;
		end else begin
			if (bc_write & ~soft_reset_active) begin
				basic_control_reg <= {1'b0, reg_wdata[14:6], 6'h00}; // [R01]
			end
			if (sense_write & ~soft_reset_active) begin
				energy_detect_ctrl_reg <= reg_wdata; // [R05]
			end
		end
	end

	function [15:0] read_mux;
		input [4:0]  addr;
		input [15:0] bc;
		input [15:0] sense;
		begin
			case (addr)
				`PRPC_OFF_BASIC_CONTROL: read_mux = bc;
				`PRPC_OFF_ENERGY_DETECT: read_mux = sense;
				default:                 read_mux = 16'h0000;
			endcase
		end
	endfunction

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata  <= 16'h0000;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				// reset bit mirrors the running reset [R13]
				reg_rdata <= read_mux(reg_addr,
					basic_control_reg | {soft_reset_active, 15'h0000}, energy_detect_ctrl_reg);
			end
		end
	end
// ****************************************************
// power states
// ****************************************************
	localparam ST_ACTIVE = 2'b00;
	localparam ST_QUIET  = 2'b01;
	localparam ST_WAKE   = 2'b10;
	localparam ST_DOWN   = 2'b11;

	reg [1:0]  state;
	reg [1:0]  next_state;
	reg [17:0] probe_cnt;
	reg [15:0] wake_cnt;
	wire       sense_enable = energy_detect_ctrl_reg[`PRPC_SENSE_ENABLE_BIT]; // [R05]
	wire       pd_bit    = basic_control_reg[`PRPC_BC_POWER_DOWN_BIT];
	wire [7:0] probe_units = energy_detect_ctrl_reg[`PRPC_SENSE_PERIOD_MSB:`PRPC_SENSE_PERIOD_LSB];
	// a period of zero counts as one unit, else a probe would go out on every cycle
	wire [17:0] probe_period = {(probe_units == 8'h00) ? 8'h01 : probe_units, 10'h000};
	wire       probe_due = (probe_cnt >= probe_period);

	always @* begin
		next_state = state;
		case (state)
			ST_ACTIVE: begin
				if (pd_bit)
					next_state = ST_DOWN; // [R01]
				else if (sense_enable & ~line_activity)
					next_state = ST_QUIET; // [R02]
			end
			ST_QUIET: begin
				if (pd_bit)
					next_state = ST_DOWN;
				else if (~sense_enable | line_activity)
					next_state = ST_WAKE; // [R03]
			end
			ST_WAKE: begin
				// power-down asked for in the middle of a wake-up is not held back
				if (pd_bit)
					next_state = ST_DOWN; // [R01]
				else if (wake_cnt >= `PRPC_WAKE_UP_CYCLES)
					next_state = ST_ACTIVE; // [R03]
			end
			ST_DOWN: begin
				if (~pd_bit)
					next_state = ST_WAKE;
			end
			default: next_state = ST_ACTIVE;
		endcase
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state                  <= ST_ACTIVE;
			probe_cnt              <= 18'h00000;
			wake_cnt               <= 16'h0000;
			power_down             <= 1'b0;
			energy_sense_low_power <= 1'b0;
			tx_wake                <= 1'b0;
			tx_probe               <= 1'b0;
		end else begin
			state    <= regs_clear ? ST_ACTIVE : next_state;
			wake_cnt <= (state == ST_WAKE) ? wake_cnt + 16'h0001 : 16'h0000;
			// probes go out whatever the line does, but not on the edge that leaves quiet
			if (state == ST_QUIET && probe_due) begin
				probe_cnt <= 18'h00000;
				tx_probe  <= (next_state == ST_QUIET) & ~regs_clear; // [R04]
			end else begin
				probe_cnt <= (state == ST_QUIET) ? probe_cnt + 18'h00001 : 18'h00000;
				tx_probe  <= 1'b0;
			end
			power_down             <= (next_state == ST_DOWN) & ~regs_clear; // [R01]
			energy_sense_low_power <= (next_state == ST_QUIET) & ~regs_clear; // [R02]
			// transmitter sleeps in quiet except around each probe [R04]
			tx_wake <= ~regs_clear & ((next_state == ST_ACTIVE) |
				((next_state == ST_QUIET) & probe_due));
		end
	end
endmodule

// File: dv/prpc_host_model.sv
// host-side model that holds the hardware reset pin low for a set time
`timescale 1ns/1ps
module prpc_host_model #(
	parameter HOLD_CYCLES = 100
) (
	input  wire clk,
	input  wire go,
	output reg  reset_n_pin
);
	integer left = 0;
	initial reset_n_pin = 1'b1;
	// holds a full microsecond, never shorter
	always @(posedge clk) begin
		if (go) begin
			left <= HOLD_CYCLES;
			reset_n_pin <= 1'b0;
		end else if (left > 1) begin
			left <= left - 1;
		end else begin
			reset_n_pin <= 1'b1;
		end
	end
endmodule

// File: dv/prpc_properties.sv
// checker for the reset and power-state block
`timescale 1ns/1ps
module prpc_properties #(
	parameter STRAP_WIDTH = 4
) (
	input wire                   clk,
	input wire                   nrst,
	input wire                   reset_n_pin,
	input wire                   reg_wr,
	input wire                   reg_rd,
	input wire [4:0]             reg_addr,
	input wire [15:0]            reg_wdata,
	input wire                   line_activity,
	input wire [15:0]            reg_rdata,
	input wire [STRAP_WIDTH-1:0] strap_latched,
	input wire                   soft_reset_active,
	input wire                   core_reset_n,
	input wire                   power_down,
	input wire                   energy_sense_low_power,
	input wire                   tx_probe
);
	// ****
	// properties
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	wire bc_wr = reg_wr && reg_addr == 5'h00 && !soft_reset_active && core_reset_n;
	a_pd_enter: assert property (bc_wr && reg_wdata[11] && !reg_wdata[15] |-> ##[1:2] power_down)
		else $error("power-down not entered");
	a_srst_start: assert property (bc_wr && reg_wdata[15] |=> soft_reset_active && !core_reset_n)
		else $error("soft reset not started");
	a_srst_length: assert property ($rose(soft_reset_active) |-> ##90 soft_reset_active ##[1:20] !soft_reset_active)
		else $error("soft reset length wrong");
	a_srst_core: assert property (soft_reset_active |-> !core_reset_n)
		else $error("core runs during soft reset");
	a_strap_kept: assert property (soft_reset_active |=> $stable(strap_latched))
		else $error("straps changed by soft reset");
	a_pin_reset: assert property (!reset_n_pin |-> ##[1:2] !core_reset_n)
		else $error("pin reset ignored");
	a_unmapped_zero: assert property (reg_rd && reg_addr != 5'h00 && reg_addr != 5'h1d |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_probe_low: assert property (tx_probe |-> energy_sense_low_power)
		else $error("probe outside low power");
	a_line_wake: assert property (energy_sense_low_power && line_activity |-> ##[1:110] !energy_sense_low_power)
		else $error("no wake on activity");
endmodule
bind prpc_core prpc_properties #(.STRAP_WIDTH(STRAP_WIDTH)) chk_i (.clk(clk), .nrst(nrst),
	.reset_n_pin(reset_n_pin), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .line_activity(line_activity), .reg_rdata(reg_rdata),
	.strap_latched(strap_latched), .soft_reset_active(soft_reset_active), .core_reset_n(core_reset_n),
	.power_down(power_down), .energy_sense_low_power(energy_sense_low_power), .tx_probe(tx_probe));

// File: dv/tb_top.sv
// self-checking bench for the reset and power-state block
`timescale 1ns/1ps
module tb_top;
	reg         clk = 1'b0;
	reg         nrst = 1'b0;
	reg  [3:0]  strap_in = 4'h5;
	reg         reg_wr = 1'b0;
	reg         reg_rd = 1'b0;
	reg  [4:0]  reg_addr = 5'h00;
	reg  [15:0] reg_wdata = 16'h0000;
	reg         line_activity = 1'b0;
	reg         pin_go = 1'b0;
	wire        reset_n_pin;
	wire [15:0] reg_rdata;
	wire [3:0]  strap_latched;
	wire        reg_rvalid, soft_reset_active, core_reset_n, power_down, esl, tx_wake, tx_probe;
	integer     failures = 0;
	integer     total_checks = 0;
	integer     n;
	integer     p;
	always #5 clk = ~clk;
	prpc_core uut (.clk(clk), .nrst(nrst), .reset_n_pin(reset_n_pin), .strap_in(strap_in),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.line_activity(line_activity), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.strap_latched(strap_latched), .soft_reset_active(soft_reset_active),
		.core_reset_n(core_reset_n), .power_down(power_down), .energy_sense_low_power(esl),
		.tx_wake(tx_wake), .tx_probe(tx_probe));
	prpc_host_model host (.clk(clk), .go(pin_go), .reset_n_pin(reset_n_pin));
	// ****
	// shared tasks
	// ****
	task chk(input string what, input [15:0] exp, input [15:0] got);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("[ERR] %0s expected %h seen %h", what, exp, got);
			end
		end
	endtask
	task cyc(input integer k);
		begin
			repeat (k) @(posedge clk);
			#1;
		end
	endtask
	// an idle edge before each strobe keeps drivers from double assignment
	task wr(input [4:0] a, input [15:0] d);
		begin
			cyc(1);
			reg_addr = a;
			reg_wdata = d;
			reg_wr = 1'b1;
			cyc(1);
			reg_wr = 1'b0;
		end
	endtask
	task rd(input [4:0] a, input [15:0] e);
		begin
			cyc(1);
			reg_addr = a;
			reg_rd = 1'b1;
			cyc(1);
			reg_rd = 1'b0;
			chk("rvalid", 16'h0001, {15'h0000, reg_rvalid});
			chk("rdata", e, reg_rdata);
		end
	endtask
	// ****
	// scenarios
	// ****
	task t_defaults;
		begin
			rd(5'h00, 16'h3000);
			rd(5'h1d, 16'h0010);
			rd(5'h05, 16'h0000);
			chk("strap", 16'h0005, {12'h000, strap_latched});
		end
	endtask
	task t_power_down;
		begin
			wr(5'h00, 16'h3800);
			rd(5'h00, 16'h3800);
			chk("pd", 16'h0001, {15'h0000, power_down});
			chk("tx_wake", 16'h0000, {15'h0000, tx_wake});
			wr(5'h00, 16'h3000);
		end
	endtask
	task t_soft_reset;
		begin
			strap_in = 4'ha;
			wr(5'h1d, 16'h8004);
			wr(5'h00, 16'h8000);
			chk("srst", 16'h0001, {15'h0000, soft_reset_active});
			n = 0;
			while (soft_reset_active !== 1'b0 && n < 300) begin
				cyc(1);
				n = n + 1;
			end
			chk("srst_len", 16'h0001, {15'h0000, n >= 90 && n <= 110});
			cyc(300); // host keeps quiet for three microseconds
			rd(5'h00, 16'h3000);
			rd(5'h1d, 16'h0010);
			chk("strap", 16'h0005, {12'h000, strap_latched});
		end
	endtask
	task t_hw_reset;
		begin
			wr(5'h1d, 16'h8004);
			strap_in = 4'h3;
			pin_go = 1'b1;
			cyc(1);
			pin_go = 1'b0;
			n = 0;
			while (reset_n_pin !== 1'b1 && n < 300) begin
				cyc(1);
				n = n + 1;
			end
			cyc(4);
			chk("strap", 16'h0003, {12'h000, strap_latched});
			rd(5'h1d, 16'h0010);
		end
	endtask
	task t_energy;
		begin
			wr(5'h1d, 16'h8001);
			cyc(300);
			chk("low_power", 16'h0001, {15'h0000, esl});
			chk("tx_wake", 16'h0000, {15'h0000, tx_wake});
			p = 0;
			for (n = 0; n < 2200; n = n + 1) begin
				cyc(1);
				p = p + tx_probe;
			end
			chk("probes", 16'h0001, {15'h0000, p >= 2});
			line_activity = 1'b1;
			cyc(200);
			chk("woken", 16'h0000, {15'h0000, esl});
			chk("tx_wake", 16'h0001, {15'h0000, tx_wake});
			wr(5'h1d, 16'h0010);
			line_activity = 1'b0;
		end
	endtask
	task tally_and_finish;
		begin
			$display("checks %0d failures %0d", total_checks, failures);
			if (failures == 0 && total_checks > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	initial begin
		cyc(8);
		nrst = 1'b1;
		cyc(4);
		t_defaults;
		t_power_down;
		t_soft_reset;
		t_hw_reset;
		t_energy;
		tally_and_finish;
	end
	initial begin
		#200000;
		failures = failures + 1;
		tally_and_finish;
	end
endmodule
